// ---- core/eiu_burst_link.sv ----
// burst sequencer on the link clock: address latch, burst clock, restart
// assumes start is a toggle from the core domain, beats held stable meanwhile
module eiu_burst_link
    import eiu_pkg::*;
(
    input wire logic linkClk,
    input wire logic srst,
    input wire logic startToggle,
    input wire logic [BEAT_W-1:0] beats,
    input wire logic burstRestartRequestN,
    output logic doneToggle,
    output logic burstClk,
    output logic burstAddressLatchN
);
    typedef enum logic [1:0] {L_IDLE, L_LATCH, L_FIRST, L_BEAT} eiu_link_state_t;

    eiu_link_state_t state_reg;
    logic linkRst;
    logic startSync;
    logic restartSync;
    logic startSeen_reg;
    logic restartPrev_reg;
    logic [BEAT_W-1:0] beatCnt_reg;
    logic [2:0] firstCnt_reg;
    logic restartFall;

    eiu_sync #(.W(1), .INIT(1'b1)) rstSync (.clk(linkClk), .srst(1'b0), .din(srst), .dout(linkRst));
    eiu_sync #(.W(1)) startSyncI (.clk(linkClk), .srst(linkRst), .din(startToggle), .dout(startSync));
    eiu_sync #(.W(1), .INIT(1'b1)) restartSyncI (.clk(linkClk), .srst(linkRst),
        .din(burstRestartRequestN), .dout(restartSync));

    assign restartFall = restartPrev_reg && !restartSync;

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
            restartPrev_reg <= 1'b1;
        else
            restartPrev_reg <= restartSync;
    end

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            state_reg <= L_IDLE;
            startSeen_reg <= 1'b0;
            doneToggle <= 1'b0;
            beatCnt_reg <= '0;
            firstCnt_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                L_IDLE:
                begin
                    if (startSync != startSeen_reg)
                    begin
                        startSeen_reg <= startSync;
                        beatCnt_reg <= '0;
                        state_reg <= L_LATCH;
                    end
                end
                L_LATCH:
                begin
                    firstCnt_reg <= '0;
                    state_reg <= L_FIRST;
                end
                L_FIRST, L_BEAT:
                begin
                    if (restartFall)
                    begin
                        beatCnt_reg <= '0;
                        state_reg <= L_LATCH;
                    end
                    else if (state_reg == L_FIRST)
                    begin
                        firstCnt_reg <= firstCnt_reg + 3'h1;
                        if (firstCnt_reg == 3'(LONG_FIRST_LINK_CYCLES - 1))
                            state_reg <= L_BEAT;
                    end
                    else if (burstClk)
                    begin
                        beatCnt_reg <= beatCnt_reg + 8'h01;
                        if (beatCnt_reg + 8'h01 >= beats)
                        begin
                            doneToggle <= ~doneToggle;
                            state_reg <= L_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // burst clock runs only in beats
    always_ff @(posedge linkClk)
    begin
        if (linkRst || state_reg != L_BEAT || restartFall)
            burstClk <= 1'b0;
        else
            burstClk <= ~burstClk;
    end

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
            burstAddressLatchN <= 1'b1;
        else
            burstAddressLatchN <= !((state_reg == L_IDLE && startSync != startSeen_reg)
                || ((state_reg == L_FIRST || state_reg == L_BEAT) && restartFall));
    end
endmodule

// ---- core/eiu_pkg.sv ----
// external interface unit: shared constants, request and answer carriers
// assumes a 25 MHz core clock and a separate burst link clock
package eiu_pkg;
    localparam int CORE_CLK_PERIOD_NS = 40;
    localparam int ACCESS_TIME_NS = 120;
    // least time, rounded up to whole core cycles
    localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int TIMEOUT_COUNT = 1022;
    localparam int TIMER_W = 10;
    localparam int LONG_FIRST_LINK_CYCLES = 4;
    localparam int BEAT_W = 8;
    localparam int ADDR_W = 26;
    localparam int PIN_ADDR_W = 25;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int CS_COUNT = 6;
    localparam int CS_SHARED_LSB = 2;
    localparam int SDRAM_CS_COUNT = 2;
    localparam int BOOT_W = 4;
    localparam int BANK_NI_W = 5;
    localparam int BANK_NI_PIN_LSB = 11;
    localparam int BANK_NI_ADDR_LSB = 21;
    localparam int BANK_IL_W = 4;
    localparam int BANK_IL_PIN_LSB = 16;
    localparam int BANK_IL_ADDR_LSB = 9;
    localparam int MA_LOW_W = 10;
    localparam int MA_PIN_LSB = 1;
    localparam int MA_ADDR_LSB = 2;
    localparam int MA_HIGH_W = 2;
    localparam logic [BOOT_W-1:0] BOOT_RESET = 4'h0;

    typedef struct packed {
        logic write;
        logic sdram;
        logic interleave;
        logic burst;
        logic useAck;
        logic [2:0] chipSel;
        logic [BEAT_W-1:0] beats;
        logic [LANES-1:0] byteEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eiu_req_t;

    typedef struct packed {
        logic error;
        logic [DATA_W-1:0] rdata;
    } eiu_rsp_t;

    // address seen on the pins for one access
    function automatic logic [PIN_ADDR_W-1:0] eiu_pin_addr(input eiu_req_t r);
        logic [PIN_ADDR_W-1:0] a;
        a = r.addr[PIN_ADDR_W-1:0];
        if (r.sdram)
        begin
            a[MA_PIN_LSB +: MA_LOW_W] = r.addr[MA_ADDR_LSB +: MA_LOW_W];
            if (r.interleave)
                a[BANK_IL_PIN_LSB +: BANK_IL_W] = r.addr[BANK_IL_ADDR_LSB +: BANK_IL_W];
            else
                a[BANK_NI_PIN_LSB +: BANK_NI_W] = r.addr[BANK_NI_ADDR_LSB +: BANK_NI_W];
        end
        return a;
    endfunction
endpackage

// ---- core/eiu_sync.sv ----
// two-flop synchroniser for a bundle of independent levels
// assumes each bit may change at any time relative to clk
module eiu_sync
    import eiu_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_reg <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// ---- core/eiu_top.sv ----
// external interface unit: pin side of async, burst and sdram accesses
// assumes one request at a time from the internal bus; pins are asynchronous
// What this block does
// - four active-low byte strobes, msb lane first
// - active-low output enable during reads
// - six selects, two shared with sdram selects
// - restart input abandons burst, long first access
// - address latch strobe captures burst start address
// - burst clock driven during burst mode
// - read/write high for read, low write
// - acknowledge missing 1022 counts gives bus error
// - boot mode taken from pins during reset
// - non-interleaved bank bits on address 15:11
// - interleaved bank bits on address 19:16
// - sdram address 9:0 on pins 10:1
module eiu_top
    import eiu_pkg::*;
#(
    parameter int ACCESS_WAIT = ACCESS_CYCLES,
    parameter int TIMEOUT_LIMIT = TIMEOUT_COUNT
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic reqValid,
    output logic reqReady,
    input wire eiu_req_t req,
    output logic rspValid,
    output eiu_rsp_t rsp,
    input wire logic [SDRAM_CS_COUNT-1:0] functionMuxControl,
    output logic [PIN_ADDR_W-1:0] addrPins,
    output logic [MA_HIGH_W-1:0] sdramRowColAddrHigh,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic byteStrobeMsbN,
    output logic byteStrobeUpperMidN,
    output logic byteStrobeLowerMidN,
    output logic byteStrobeLsbN,
    output logic outputEnableN,
    output logic readWrite,
    output logic [CS_COUNT-1:0] chipSelectN,
    input wire logic burstRestartRequestN,
    output logic burstAddressLatchN,
    output logic burstClk,
    input wire logic externalTransferAckN,
    input wire logic [BOOT_W-1:0] bootSelect,
    output logic [BOOT_W-1:0] bootMode
);
    typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_BURST, S_DONE} eiu_state_t;

    eiu_state_t state_reg;
    eiu_req_t cur_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic timeout_reg;
    logic ackArmed_reg;
    logic startToggle_reg;
    logic doneSeen_reg;
    logic [SDRAM_CS_COUNT-1:0] muxSel_reg;
    logic [LANES-1:0] strobeN_reg;
    logic [CS_COUNT-1:0] csN_reg;
    logic [SDRAM_CS_COUNT-1:0] sdramCsN_reg;
    logic linkDoneToggle;
    logic doneSync;
    logic ackSync;
    logic [BOOT_W-1:0] bootSync;
    logic [DATA_W-1:0] dataSync;
    logic take;
    logic ackSeen;
    logic timeUp;

    eiu_sync #(.W(1), .INIT(1'b1)) ackSyncI (.clk(core_clk), .srst(srst),
        .din(externalTransferAckN), .dout(ackSync));
    eiu_sync #(.W(1)) doneSyncI (.clk(core_clk), .srst(srst),
        .din(linkDoneToggle), .dout(doneSync));
    eiu_sync #(.W(BOOT_W)) bootSyncI (.clk(core_clk), .srst(1'b0),
        .din(bootSelect), .dout(bootSync));
    eiu_sync #(.W(DATA_W)) dataSyncI (.clk(core_clk), .srst(srst),
        .din(dataIn), .dout(dataSync));

    eiu_burst_link burstLink (
        .linkClk(linkClk),
        .srst(srst),
        .startToggle(startToggle_reg),
        .beats(cur_reg.beats),
        .burstRestartRequestN(burstRestartRequestN),
        .doneToggle(linkDoneToggle),
        .burstClk(burstClk),
        .burstAddressLatchN(burstAddressLatchN)
    );

    assign reqReady = (state_reg == S_IDLE) && !srst;
    assign take = reqValid && reqReady;
    assign ackSeen = cur_reg.useAck && ackArmed_reg && !ackSync;
    assign timeUp = cur_reg.useAck && (timer_reg >= TIMER_W'(TIMEOUT_LIMIT));

    // boot pins followed while reset held
    always_ff @(posedge core_clk)
    begin
        if (srst)
            bootMode <= bootSync;
    end

    // sdram selects routed out during reset, then per functionMuxControl
    always_ff @(posedge core_clk)
    begin
        if (srst)
            muxSel_reg <= '0;
        else
            muxSel_reg <= functionMuxControl;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg <= S_IDLE;
            cur_reg <= '0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                S_IDLE:
                begin
                    if (take)
                    begin
                        cur_reg <= req;
                        timeout_reg <= 1'b0;
                        state_reg <= req.burst ? S_BURST : S_ACCESS;
                    end
                end
                S_ACCESS:
                begin
                    if (ackSeen)
                        state_reg <= S_DONE;
                    else if (timeUp)
                    begin
                        timeout_reg <= 1'b1;
                        state_reg <= S_DONE;
                    end
                    else if (!cur_reg.useAck && timer_reg >= TIMER_W'(ACCESS_WAIT - 1))
                        state_reg <= S_DONE;
                end
                S_BURST:
                begin
                    if (doneSync != doneSeen_reg)
                        state_reg <= S_DONE;
                end
                S_DONE:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    // synced ack lags two cycles, so a late low from the previous access
    // would otherwise end a back-to-back access at once
    // ack armed once released
    always_ff @(posedge core_clk)
    begin
        if (srst || take)
            ackArmed_reg <= 1'b0;
        else if (state_reg == S_ACCESS && ackSync)
            ackArmed_reg <= 1'b1;
    end

    // cycle counter doubles as wait-state and time-out monitor
    always_ff @(posedge core_clk)
    begin
        if (srst || state_reg != S_ACCESS)
            timer_reg <= '0;
        else if (timer_reg != '1)
            timer_reg <= timer_reg + TIMER_W'(1);
    end

    // event crossing to the link: toggle out, toggle back
    always_ff @(posedge core_clk)
    begin
        if (srst)
            startToggle_reg <= 1'b0;
        else if (take && req.burst)
            startToggle_reg <= ~startToggle_reg;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            doneSeen_reg <= 1'b0;
        else
            doneSeen_reg <= doneSync;
    end

    // one answer per access, error flagged
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rspValid <= 1'b0;
            rsp <= '0;
        end
        else
        begin
            rspValid <= (state_reg == S_DONE);
            if (state_reg == S_DONE)
            begin
                rsp.error <= timeout_reg;
                rsp.rdata <= (cur_reg.write || timeout_reg) ? '0 : dataSync;
            end
        end
    end

    // pins settle one cycle after the request is taken
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            addrPins <= '0;
            sdramRowColAddrHigh <= '0;
            dataOut <= '0;
            dataOe <= 1'b0;
            outputEnableN <= 1'b1;
            readWrite <= 1'b1;
            strobeN_reg <= '1;
        end
        else if (take)
        begin
            addrPins <= eiu_pin_addr(req);
            sdramRowColAddrHigh <= req.sdram ?
                req.addr[MA_ADDR_LSB + MA_LOW_W +: MA_HIGH_W] : '0;
            dataOut <= req.wdata;
            dataOe <= req.write;
            outputEnableN <= req.write;
            readWrite <= !req.write;
            strobeN_reg <= req.write ? ~req.byteEn : '0;
        end
        else if (state_reg == S_DONE || state_reg == S_IDLE)
        begin
            dataOe <= 1'b0;
            outputEnableN <= 1'b1;
            readWrite <= 1'b1;
            strobeN_reg <= '1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            csN_reg <= '1;
            sdramCsN_reg <= '1;
        end
        else if (take)
        begin
            csN_reg <= '1;
            sdramCsN_reg <= '1;
            if (req.sdram)
                sdramCsN_reg[req.chipSel[0]] <= 1'b0;
            else if (req.chipSel < 3'(CS_COUNT))
                csN_reg[req.chipSel] <= 1'b0;
        end
        else if (state_reg == S_DONE || state_reg == S_IDLE)
        begin
            csN_reg <= '1;
            sdramCsN_reg <= '1;
        end
    end

    // shared pins pick select or sdram select
    always_comb
    begin
        chipSelectN = csN_reg;
        for (int i = 0; i < SDRAM_CS_COUNT; i++)
        begin
            if (!muxSel_reg[i])
                chipSelectN[CS_SHARED_LSB + i] = sdramCsN_reg[i];
        end
    end

    assign byteStrobeMsbN = strobeN_reg[3];
    assign byteStrobeUpperMidN = strobeN_reg[2];
    assign byteStrobeLowerMidN = strobeN_reg[1];
    assign byteStrobeLsbN = strobeN_reg[0];
endmodule

// ---- verification/eiu_asserts.sv ----
// checker: pin relations of the external interface unit
// assumes it is bound into eiu_top and sees only its ports
module eiu_asserts
    import eiu_pkg::*;
#(
    parameter int ACCESS_WAIT = ACCESS_CYCLES,
    parameter int TIMEOUT_LIMIT = TIMEOUT_COUNT
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire eiu_req_t req,
    input wire logic rspValid,
    input wire logic [PIN_ADDR_W-1:0] addrPins,
    input wire logic dataOe,
    input wire logic byteStrobeMsbN,
    input wire logic byteStrobeUpperMidN,
    input wire logic byteStrobeLowerMidN,
    input wire logic byteStrobeLsbN,
    input wire logic outputEnableN,
    input wire logic readWrite,
    input wire logic [CS_COUNT-1:0] chipSelectN,
    input wire logic burstAddressLatchN
);
    localparam int RD_LAT = ACCESS_WAIT + 2;
    localparam int TO_MAX = TIMEOUT_LIMIT + 8;
    eiu_req_t held_reg;
    logic take;
    logic [3:0] stb;
    assign take = reqValid && reqReady;
    assign stb = {byteStrobeMsbN, byteStrobeUpperMidN, byteStrobeLowerMidN, byteStrobeLsbN};
    // request kept so pins can be judged later
    always_ff @(posedge core_clk)
    begin
        if (take)
            held_reg <= req;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    oe_read_a: assert property (!outputEnableN |-> readWrite && !dataOe)
        else $error("output enable outside a read");
    rw_write_a: assert property (dataOe |-> !readWrite)
        else $error("write without low read/write");
    read_lanes_a: assert property (!outputEnableN |-> stb == 4'h0)
        else $error("read without all lanes");
    write_lanes_a: assert property (dataOe |-> stb == ~held_reg.byteEn)
        else $error("write lanes differ from byte enables");
    bank_ni_a: assert property (take && req.sdram && !req.interleave |-> ##2
        addrPins[15:11] == held_reg.addr[25:21] && addrPins[10:1] == held_reg.addr[11:2])
        else $error("sdram bank or column bits wrong");
    bank_il_a: assert property (take && req.sdram && req.interleave |-> ##2
        addrPins[19:16] == held_reg.addr[12:9])
        else $error("interleaved bank bits wrong");
    select_zero_a: assert property (take && !req.sdram && !req.burst && req.chipSel == 3'h0
        |-> ##2 chipSelectN == 6'h3E)
        else $error("select 0 not alone");
    timeout_a: assert property (take && req.useAck && !req.burst
        |-> ##[1:TO_MAX] rspValid)
        else $error("acknowledged access never ended");
    read_lat_a: assert property (take && !req.useAck && !req.burst && !req.sdram && !req.write
        |-> ##[RD_LAT:RD_LAT] rspValid)
        else $error("plain read answer late or early");
    idle_back_a: assert property (rspValid |-> reqReady && outputEnableN && !dataOe)
        else $error("answer without idle pins");
    latch_busy_a: assert property (!burstAddressLatchN |-> !reqReady)
        else $error("address latch while idle");
    cover property (take && req.burst);
    cover property (take && req.sdram && req.interleave);
    cover property (take && req.useAck);
endmodule

bind eiu_top eiu_asserts #(.ACCESS_WAIT(ACCESS_WAIT), .TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk (
    .core_clk, .srst, .reqValid, .reqReady, .req, .rspValid, .addrPins, .dataOe,
    .byteStrobeMsbN, .byteStrobeUpperMidN, .byteStrobeLowerMidN, .byteStrobeLsbN,
    .outputEnableN, .readWrite, .chipSelectN, .burstAddressLatchN);

// ---- verification/eiu_flash_model.sv ----
// memory model: async data, acknowledge, burst latch and restart
// assumes the bench sets ackDelay and restartOn between accesses
module eiu_flash_model
    import eiu_pkg::*;
(
    input wire logic core_clk,
    input wire logic linkClk,
    input wire logic outputEnableN,
    input wire logic [CS_COUNT-1:0] chipSelectN,
    input wire logic [PIN_ADDR_W-1:0] addrPins,
    input wire logic burstAddressLatchN,
    input wire logic burstClk,
    input wire logic [3:0] ackDelay,
    input wire logic restartOn,
    output logic [DATA_W-1:0] dataIn = 32'h0000_0000,
    output logic externalTransferAckN = 1'b1,
    output logic burstRestartRequestN = 1'b1,
    output int latchCount = 0,
    output int clkRises = 0,
    output logic [PIN_ADDR_W-1:0] latchedAddr
);
    int ackCnt = 0;
    int beat = 0;
    logic clkPrev = 1'b0;
    logic restarted = 1'b0;
    // data only while enabled; released bus flips
    always @(posedge core_clk)
        dataIn <= !outputEnableN ? {7'h00, addrPins} ^ 32'hA5A5_A5A5 : ~dataIn;
    // ack after ackDelay, never when zero
    always @(posedge core_clk)
    begin
        ackCnt <= &chipSelectN ? 0 : ackCnt + 1;
        externalTransferAckN <= !(ackDelay != 4'h0 && !(&chipSelectN) && ackCnt >= ackDelay);
    end
    // capture start, count clock, restart once
    always @(posedge linkClk)
    begin
        clkPrev <= burstClk;
        burstRestartRequestN <= 1'b1;
        if (!restartOn)
            restarted <= 1'b0;
        if (!burstAddressLatchN)
        begin
            latchCount <= latchCount + 1;
            latchedAddr <= addrPins;
            beat <= 0;
        end
        else if (burstClk && !clkPrev)
        begin
            clkRises <= clkRises + 1;
            beat <= beat + 1;
            if (restartOn && !restarted && beat == 1)
            begin
                burstRestartRequestN <= 1'b0;
                restarted <= 1'b1;
            end
        end
    end
endmodule

// ---- verification/test_external_bus_pin_interface.sv ----
// bench: drives eiu_top requests and judges its pins and answers
// assumes the memory model stands on the pins; timeout cut to 20
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch %0t %s", $time, m); end end
module test_external_bus_pin_interface
    import eiu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, srst = 1, linkClk = 0, reqValid = 0, reqReady, rspValid, dataOe;
    eiu_req_t req = '0;
    eiu_rsp_t rsp, gotRsp;
    logic [1:0] functionMuxControl = 2'h0, sdramRowColAddrHigh, snapHigh;
    logic [PIN_ADDR_W-1:0] addrPins, snapAddr, latchedAddr;
    logic [31:0] dataIn, dataOut, snapData;
    logic byteStrobeMsbN, byteStrobeUpperMidN, byteStrobeLowerMidN, byteStrobeLsbN;
    logic outputEnableN, readWrite, burstRestartRequestN, burstAddressLatchN, burstClk;
    logic externalTransferAckN, restartOn = 0, snapRw, snapOe, gotValid;
    logic [5:0] chipSelectN, snapCs;
    logic [3:0] bootSelect = 4'hA, bootMode, ackDelay = 4'h0, snapStb;
    logic [3:0] bes [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hA};
    int mismatches = 0, n_compared = 0, lat, latchCount, clkRises, n0, c0;
    eiu_top #(.TIMEOUT_LIMIT(20)) dut (.core_clk, .srst, .linkClk, .reqValid, .reqReady,
        .req, .rspValid, .rsp, .functionMuxControl, .addrPins, .sdramRowColAddrHigh,
        .dataIn, .dataOut, .dataOe, .byteStrobeMsbN, .byteStrobeUpperMidN,
        .byteStrobeLowerMidN, .byteStrobeLsbN, .outputEnableN, .readWrite, .chipSelectN,
        .burstRestartRequestN, .burstAddressLatchN, .burstClk, .externalTransferAckN,
        .bootSelect, .bootMode);
    eiu_flash_model mem (.core_clk, .linkClk, .outputEnableN, .chipSelectN, .addrPins,
        .burstAddressLatchN, .burstClk, .ackDelay, .restartOn, .dataIn, .externalTransferAckN,
        .burstRestartRequestN, .latchCount, .clkRises, .latchedAddr);
    always #20 core_clk = ~core_clk;
    // link clock offset so its edges never meet the core edges
    initial
    begin
        #7;
        forever #40 linkClk = ~linkClk;
    end
    function automatic eiu_req_t mk(logic [4:0] f, logic [2:0] cs, logic [3:0] be,
        logic [25:0] a);
        return '{f[4], f[3], f[2], f[1], f[0], cs, 8'h04, be, a, {6'h00, a} ^ 32'h0F0F_F0F0};
    endfunction
    task automatic xfer(input eiu_req_t r);
        @(posedge core_clk);
        reqValid <= 1'b1;
        req <= r;
        @(posedge core_clk);
        reqValid <= 1'b0;
        lat = 0;
        gotValid = 0;
        while (!gotValid && lat < 3000)
        begin
            @(posedge core_clk);
            #1;
            lat++;
            if (lat == 2)
            begin
                snapAddr = addrPins;
                snapHigh = sdramRowColAddrHigh;
                snapData = dataOut;
                snapStb = {byteStrobeMsbN, byteStrobeUpperMidN, byteStrobeLowerMidN,
                    byteStrobeLsbN};
                {snapRw, snapOe, snapCs} = {readWrite, outputEnableN, chipSelectN};
            end
            gotValid = rspValid === 1'b1;
        end
        gotRsp = rsp;
        `CHK(gotValid, 1'b1, "no answer")
    endtask
    task automatic t_boot;
        @(posedge core_clk);
        #1;
        `CHK(bootMode, 4'hA, "boot mode")
        @(posedge core_clk);
        bootSelect <= 4'h5;
        repeat (4) @(posedge core_clk);
        `CHK(bootMode, 4'hA, "boot mode moved")
    endtask
    task automatic t_read;
        xfer(mk(5'h00, 3'h1, 4'hF, 26'h012_3456));
        `CHK(snapOe, 1'b0, "oe")
        `CHK(snapRw, 1'b1, "rw read")
        `CHK(snapStb, 4'h0, "read lanes")
        `CHK(snapCs, 6'h3D, "select 1")
        `CHK(snapAddr, 25'h012_3456, "address")
        // answer launched at take edge + wait + 1, seen just after that edge
        `CHK(lat, ACCESS_CYCLES + 1, "read latency")
        `CHK(gotRsp.rdata, 32'hA5B7_91F3, "read data")
    endtask
    task automatic t_write;
        for (int i = 0; i < 5; i++)
        begin
            xfer(mk(5'h10, 3'h4, bes[i], {22'h00_0000, bes[i]}));
            `CHK(snapStb, ~bes[i], "write lanes")
            `CHK(snapRw, 1'b0, "rw write")
            `CHK(snapOe, 1'b1, "oe in write")
            `CHK(snapCs, 6'h2F, "select 4")
            `CHK(snapData, {28'h0F0_FF0F, bes[i] ^ 4'h0}, "write data")
        end
    endtask
    task automatic t_sdram;
        xfer(mk(5'h08, 3'h1, 4'hF, 26'h2A5_5A5A));
        `CHK(snapAddr[15:11], 5'h15, "bank bits")
        `CHK(snapAddr[10:1], 10'h296, "column bits")
        `CHK(snapHigh, 2'h1, "high column bits")
        `CHK(snapCs, 6'h37, "sdram select 1")
        xfer(mk(5'h0C, 3'h0, 4'hF, 26'h2A5_5A5A));
        `CHK(snapAddr[19:16], 4'hD, "interleave bank")
        @(posedge core_clk);
        functionMuxControl <= 2'h3;
        xfer(mk(5'h00, 3'h3, 4'hF, 26'h000_0040));
        `CHK(snapCs, 6'h37, "select 3 routed")
    endtask
    task automatic t_ack;
        @(posedge core_clk);
        ackDelay <= 4'h3;
        xfer(mk(5'h01, 3'h0, 4'hF, 26'h000_0200));
        `CHK(gotRsp.error, 1'b0, "ack error")
        @(posedge core_clk);
        ackDelay <= 4'h0;
        xfer(mk(5'h01, 3'h0, 4'hF, 26'h000_0200));
        `CHK({gotRsp.error, gotRsp.rdata}, 33'h1_0000_0000, "timeout answer")
        `CHK(lat >= 20, 1'b1, "timeout early")
        `CHK(reqReady, 1'b1, "idle after timeout")
    endtask
    task automatic t_burst;
        n0 = latchCount;
        c0 = clkRises;
        xfer(mk(5'h02, 3'h0, 4'hF, 26'h001_2340));
        `CHK(latchCount - n0, 1, "one latch")
        `CHK(latchedAddr, 25'h001_2340, "latched start")
        // one burst clock rise per beat, four beats asked for
        `CHK(clkRises - c0, 4, "burst clock")
        @(posedge core_clk);
        restartOn <= 1'b1;
        xfer(mk(5'h02, 3'h0, 4'hF, 26'h001_2340));
        `CHK(latchCount - n0, 3, "restart latch")
        restartOn <= 1'b0;
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #400_000;
        mismatches++;
        give_verdict;
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        t_boot;
        t_read;
        t_write;
        t_sdram;
        t_ack;
        t_burst;
        give_verdict;
    end
endmodule
